/* verilog/llcev_pkg.sv */
package llcev_pkg;
   // ==========================================
   // register map (byte addresses on the apb bus)
   localparam int unsigned NCNT = 2;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_SEL0 = 8'h10;
   localparam logic [7:0] ADDR_CNT0 = 8'h14;
   localparam logic [7:0] ADDR_STRIDE = 8'h08;
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_STAT = 4'h1;
   localparam logic [3:0] IDX_SEL0 = 4'h2;
   localparam logic [3:0] IDX_NONE = 4'hF;
   // ==========================================
   // field positions and reset values
   localparam int unsigned CTRL_DUAL_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int unsigned SEL_EV_LSB = 0;
   localparam int unsigned SEL_UM_LSB = 8;
   localparam int unsigned SEL_EN_BIT = 16;
   localparam int unsigned SEL_W = 17;
   localparam int unsigned STAT_BUSY_LSB = 0;
   localparam int unsigned STAT_FULL_LSB = 3;
   localparam int unsigned STAT_ARM_LSB = 8;
   // ==========================================
   // event codes
   localparam logic [7:0] EV_HIT = 8'h08;
   localparam logic [7:0] EV_MISS = 8'h09;
   localparam logic [7:0] EV_FILL = 8'h0A;
   localparam logic [7:0] EV_EVICT = 8'h0B;
   localparam logic [7:0] EV_REQ = 8'h20;
   localparam logic [7:0] EV_FULL = 8'h21;
   localparam logic [7:0] EV_BUSY = 8'h22;
   localparam logic [7:0] EV_OCC = 8'h23;
   // ==========================================
   // trackers: index equals the unit mask bit position for events 21, 22 and 23
   localparam int unsigned NTRK = 3;
   localparam int unsigned TRK_IO = 0;
   localparam int unsigned TRK_REM = 1;
   localparam int unsigned TRK_LOC = 2;
   localparam logic [5:0] DEPTH_DUAL_LOC = 6'h18;
   localparam logic [5:0] DEPTH_DUAL_REM = 6'h10;
   localparam logic [5:0] DEPTH_DUAL_IO = 6'h18;
   localparam logic [5:0] DEPTH_SINGLE = 6'h20;
   // ==========================================
   // event carriers
   typedef struct packed {
      logic lookup;
      logic rd;
      logic wr;
      logic probe;
      logic hit;
      logic from_link;
      logic fill;
      logic [3:0] fill_st;
      logic evict;
      logic [4:0] evict_st;
      logic snoop_hitm;
   } llcev_cache_t;
   typedef struct packed {
      logic alloc;
      logic alloc_wr;
      logic dealloc;
      logic dealloc_wr;
   } llcev_trk_t;
   typedef enum logic {AP_IDLE, AP_DONE} llcev_apb_t;
endpackage

/* verilog/llcev_counter.sv */
// Summary of operation
// - Event 08 counts read hits (01), write hits (02), both (03) and peer-probe hits (04).
// - Event 09 counts read misses (01), write misses (02), both (03) and peer-probe misses (04).
// - Combined hit and miss selections count only local core requests, never link requests.
// - Event 0A counts fills in modified 01, exclusive 02, shared 04, forward 08, any 0F.
// - Event 0B counts evictions in M 01, E 02, S 04, I 08, F 10 state, any 1F.
// - Local misses go to the home logic as speculative fetches that a hit-modified snoop may cancel.
// - The home logic keeps io hub, remote and local trackers and tags each entry read or write.
// - In dual-socket mode the depths are local 24, remote 16 and io hub 24.
// - In single-socket mode only local and io hub trackers exist, each 32 deep.
// - Event 23 adds each cycle the read entries held in the selected trackers (io 01, rem 02, loc 04).
// - Event 20 counts accepted tracker requests: io rd 01, io wr 02, rem rd 04, rem wr 08, loc rd 10, loc wr 20.
// - Event 21 adds each cycle the number of selected trackers that are full.
// - Event 22 adds each cycle the number of selected trackers that hold at least one entry.
// - Occupancy and request counting agree, so occupancy over reads gives the mean read latency.
// - Occupancy counting starts only after a bus lock seen since the occupancy event was programmed.
//
// Local design decisions: the APB register port and the register offsets.
module llcev_counter
   import llcev_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire llcev_cache_t i_cache,
   input wire llcev_trk_t [NTRK-1:0] i_trk,
   input wire logic i_bus_lock,
   output logic o_spec_fetch,
   output logic o_fetch_cancel,
   output logic [NTRK-1:0] o_trk_full
);
   // ==========================================
   // decoding helpers
   function automatic logic [3:0] reg_index(input logic [7:0] addr);
      logic [3:0] idx;
      idx = IDX_NONE;
      if (addr == ADDR_CTRL) begin
         idx = IDX_CTRL;
      end
      if (addr == ADDR_STAT) begin
         idx = IDX_STAT;
      end
      for (int k = 0; k < NCNT; k++) begin
         if (addr == ADDR_SEL0 + 8'(k) * ADDR_STRIDE) begin
            idx = IDX_SEL0 + 4'(2 * k);
         end
         if (addr == ADDR_CNT0 + 8'(k) * ADDR_STRIDE) begin
            idx = IDX_SEL0 + 4'(2 * k + 1);
         end
      end
      return idx;
   endfunction

   function automatic logic [5:0] trk_depth(input int t, input logic dual);
      logic [5:0] d;
      d = DEPTH_SINGLE;
      if (dual) begin
         d = (t == TRK_LOC) ? DEPTH_DUAL_LOC : (t == TRK_REM) ? DEPTH_DUAL_REM : DEPTH_DUAL_IO;
      end else if (t == TRK_REM) begin
         d = 6'h00;
      end
      return d;
   endfunction

   function automatic logic [7:0] evt_inc(input logic [7:0] ev, input logic [7:0] um,
                                          input llcev_cache_t c, input logic [5:0] req,
                                          input logic [2:0] full, input logic [2:0] busy,
                                          input logic [2:0][5:0] rd);
      logic [7:0] n;
      logic core_rd;
      logic core_wr;
      n = 8'h00;
      core_rd = c.lookup & c.rd & ~c.from_link;
      core_wr = c.lookup & c.wr & ~c.from_link;
      case (ev)
         EV_HIT: begin
            n = {7'h00, c.hit & ((um[0] & core_rd) | (um[1] & core_wr) |
                                 (um[2] & c.lookup & c.probe))};
         end
         EV_MISS: begin
            n = {7'h00, ~c.hit & ((um[0] & core_rd) | (um[1] & core_wr) |
                                  (um[2] & c.lookup & c.probe))};
         end
         EV_FILL: begin
            n = {7'h00, c.fill & (|(um[3:0] & c.fill_st))};
         end
         EV_EVICT: begin
            n = {7'h00, c.evict & (|(um[4:0] & c.evict_st))};
         end
         EV_REQ: begin
            for (int b = 0; b < 6; b++) begin
               n = n + {7'h00, um[b] & req[b]};
            end
         end
         EV_FULL: begin
            for (int t = 0; t < NTRK; t++) begin
               n = n + {7'h00, um[t] & full[t]};
            end
         end
         EV_BUSY: begin
            for (int t = 0; t < NTRK; t++) begin
               n = n + {7'h00, um[t] & busy[t]};
            end
         end
         EV_OCC: begin
            for (int t = 0; t < NTRK; t++) begin
               if (um[t]) begin
                  n = n + {2'b00, rd[t]};
               end
            end
         end
         default: begin
            n = 8'h00;
         end
      endcase
      return n;
   endfunction

   // ==========================================
   // state
   llcev_apb_t ap_q, ap_d;
   logic pready_d, pslverr_d;
   logic [31:0] prdata_d;
   logic dual_q, dual_d;
   logic [NCNT-1:0][SEL_W-1:0] sel_q, sel_d;
   logic [NCNT-1:0][31:0] cnt_q, cnt_d;
   logic [NCNT-1:0] armed_q, armed_d;
   logic [NCNT-1:0] cnt_wr;
   logic [NTRK-1:0][5:0] ent_q, ent_d, rdent_q, rdent_d;
   logic [NTRK-1:0] full_q, full_d, busy_w;
   logic [5:0] req_w;
   logic spec_d, cancel_d, pend_q, pend_d;
   logic wr_fire;
   logic [3:0] widx;

   assign wr_fire = (ap_q == AP_DONE) && i_psel && i_penable && i_pwrite;
   assign widx = reg_index(i_paddr);

   // ==========================================
   // apb slave: answers in the first cycle of the access phase, with no wait state
   always_comb begin
      logic [3:0] ridx;
      ridx = reg_index(i_paddr);
      ap_d = ap_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = o_prdata;
      case (ap_q)
         AP_IDLE: begin
            if (i_psel && !i_penable) begin
               ap_d = AP_DONE;
               pready_d = 1'b1;
               pslverr_d = (ridx == IDX_NONE);
               prdata_d = 32'h0000_0000;
               if (!i_pwrite) begin
                  if (ridx == IDX_CTRL) begin
                     prdata_d[CTRL_DUAL_BIT] = dual_q;
                  end
                  if (ridx == IDX_STAT) begin
                     prdata_d[STAT_BUSY_LSB +: NTRK] = busy_w;
                     prdata_d[STAT_FULL_LSB +: NTRK] = full_q;
                     prdata_d[STAT_ARM_LSB +: NCNT] = armed_q;
                  end
                  for (int k = 0; k < NCNT; k++) begin
                     if (ridx == IDX_SEL0 + 4'(2 * k)) begin
                        prdata_d[SEL_W-1:0] = sel_q[k];
                     end
                     if (ridx == IDX_SEL0 + 4'(2 * k + 1)) begin
                        prdata_d = cnt_q[k];
                     end
                  end
               end
            end
         end
         AP_DONE: begin
            ap_d = AP_IDLE;
         end
         default: begin
            ap_d = AP_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ap_q <= AP_IDLE;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end else if (i_ce) begin
         ap_q <= ap_d;
         o_pready <= pready_d;
         o_pslverr <= pslverr_d;
         o_prdata <= prdata_d;
      end
   end

   // ==========================================
   // home logic trackers
   // a full or absent tracker drops the allocation, so no allocation takes a count past the depth
   always_comb begin
      logic [5:0] dep;
      logic acc;
      logic rel;
      logic rrel;
      dep = 6'h00;
      acc = 1'b0;
      rel = 1'b0;
      rrel = 1'b0;
      for (int t = 0; t < NTRK; t++) begin
         dep = trk_depth(t, dual_q);
         acc = i_trk[t].alloc && (ent_q[t] < dep);
         rel = i_trk[t].dealloc && (ent_q[t] != 6'h00);
         rrel = i_trk[t].dealloc && !i_trk[t].dealloc_wr && (rdent_q[t] != 6'h00);
         ent_d[t] = ent_q[t] + {5'h00, acc} - {5'h00, rel};
         rdent_d[t] = rdent_q[t] + {5'h00, acc & ~i_trk[t].alloc_wr} - {5'h00, rrel};
         full_d[t] = (dep != 6'h00) && (ent_d[t] == dep);
         busy_w[t] = (ent_q[t] != 6'h00);
         req_w[2 * t] = acc & ~i_trk[t].alloc_wr;
         req_w[2 * t + 1] = acc & i_trk[t].alloc_wr;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ent_q <= '0;
         rdent_q <= '0;
         full_q <= '0;
         o_trk_full <= '0;
      end else if (i_ce) begin
         ent_q <= ent_d;
         rdent_q <= rdent_d;
         full_q <= full_d;
         o_trk_full <= full_d;
      end
   end

   // ==========================================
   // speculative fetch toward the home logic
   always_comb begin
      spec_d = i_cache.lookup && !i_cache.hit && !i_cache.probe && !i_cache.from_link;
      cancel_d = i_cache.snoop_hitm && pend_q;
      pend_d = pend_q;
      if (cancel_d || i_trk[TRK_LOC].alloc) begin
         pend_d = 1'b0;
      end
      if (spec_d) begin
         pend_d = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pend_q <= 1'b0;
         o_spec_fetch <= 1'b0;
         o_fetch_cancel <= 1'b0;
      end else if (i_ce) begin
         pend_q <= pend_d;
         o_spec_fetch <= spec_d;
         o_fetch_cancel <= cancel_d;
      end
   end

   // ==========================================
   // configuration and counters
   // a software load wins over a same-cycle increment; a bus lock wins over the disarm from programming the occupancy event
   always_comb begin
      logic [7:0] ev;
      logic [7:0] inc;
      ev = 8'h00;
      inc = 8'h00;
      dual_d = dual_q;
      if (wr_fire && widx == IDX_CTRL) begin
         dual_d = i_pwdata[CTRL_DUAL_BIT];
      end
      for (int k = 0; k < NCNT; k++) begin
         sel_d[k] = sel_q[k];
         armed_d[k] = armed_q[k];
         cnt_wr[k] = wr_fire && (widx == IDX_SEL0 + 4'(2 * k + 1));
         if (wr_fire && widx == IDX_SEL0 + 4'(2 * k)) begin
            sel_d[k] = i_pwdata[SEL_W-1:0];
            if (i_pwdata[SEL_EV_LSB +: 8] == EV_OCC) begin
               armed_d[k] = 1'b0;
            end
         end
         if (i_bus_lock) begin
            armed_d[k] = 1'b1;
         end
         ev = sel_q[k][SEL_EV_LSB +: 8];
         inc = evt_inc(ev, sel_q[k][SEL_UM_LSB +: 8], i_cache, req_w, full_q, busy_w,
                       rdent_q);
         if (ev == EV_OCC && !armed_q[k]) begin
            inc = 8'h00;
         end
         cnt_d[k] = cnt_q[k];
         if (cnt_wr[k]) begin
            cnt_d[k] = i_pwdata;
         end else if (sel_q[k][SEL_EN_BIT]) begin
            cnt_d[k] = cnt_q[k] + {24'h00_0000, inc};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         dual_q <= CTRL_RESET[CTRL_DUAL_BIT];
         sel_q <= '0;
         cnt_q <= '0;
         armed_q <= '0;
      end else if (i_ce) begin
         dual_q <= dual_d;
         sel_q <= sel_d;
         cnt_q <= cnt_d;
         armed_q <= armed_d;
      end
   end

   // ==========================================
   // checks on counter 0, the trackers, the speculative fetch and the apb answer
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_cnt0_free(logic [7:0] ev, logic [7:0] um);
      i_ce && !cnt_wr[0] && sel_q[0][SEL_EN_BIT] && sel_q[0][SEL_EV_LSB +: 8] == ev &&
      sel_q[0][SEL_UM_LSB +: 8] == um;
   endsequence

   AST_READ_HIT: assert property (s_cnt0_free(EV_HIT, 8'h01) ##0 (i_cache.lookup &&
      i_cache.hit && i_cache.rd && !i_cache.wr && !i_cache.from_link)
      |=> cnt_q[0] == $past(cnt_q[0]) + 32'h0000_0001)
      else $error("read hit not counted");
   AST_ANY_MISS_LINK: assert property (s_cnt0_free(EV_MISS, 8'h03) ##0
      (!i_cache.lookup || i_cache.from_link) |=> cnt_q[0] == $past(cnt_q[0]))
      else $error("link request counted as core miss");
   AST_FILL_ANY: assert property (s_cnt0_free(EV_FILL, 8'h0F) ##0 (i_cache.fill &&
      i_cache.fill_st != 4'h0) |=> cnt_q[0] == $past(cnt_q[0]) + 32'h0000_0001)
      else $error("fill not counted");
   AST_EVICT_I: assert property (s_cnt0_free(EV_EVICT, 8'h08) ##0 (i_cache.evict &&
      i_cache.evict_st == 5'h08) |=> cnt_q[0] == $past(cnt_q[0]) + 32'h0000_0001)
      else $error("invalid eviction not counted");
   AST_SPEC_FETCH: assert property (i_ce && i_cache.lookup && !i_cache.hit &&
      !i_cache.probe && !i_cache.from_link |=> o_spec_fetch)
      else $error("miss not forwarded");
   AST_TRK_DEPTH: assert property (ent_q[TRK_LOC] <= (dual_q ? DEPTH_DUAL_LOC :
      DEPTH_SINGLE) && ent_q[TRK_REM] <= DEPTH_DUAL_REM)
      else $error("tracker beyond its depth");
   AST_NO_REMOTE: assert property (!dual_q && i_ce && ent_q[TRK_REM] == 6'h00
      |=> ent_q[TRK_REM] == 6'h00)
      else $error("remote tracker used in single socket");
   AST_FULL_CYC: assert property (s_cnt0_free(EV_FULL, 8'h04) ##0 full_q[TRK_LOC]
      |=> cnt_q[0] == $past(cnt_q[0]) + 32'h0000_0001)
      else $error("full cycle not counted");
   AST_OCC_GATE: assert property (s_cnt0_free(EV_OCC, 8'h04) ##0 !armed_q[0]
      |=> cnt_q[0] == $past(cnt_q[0]))
      else $error("occupancy counted before bus lock");
   AST_OCC_SUM: assert property (s_cnt0_free(EV_OCC, 8'h04) ##0 armed_q[0]
      |=> cnt_q[0] == $past(cnt_q[0]) + {26'h000_0000, $past(rdent_q[TRK_LOC])})
      else $error("occupancy sum wrong");
   AST_APB_ANSWER: assert property (i_ce && i_psel && !i_penable && ap_q == AP_IDLE
      |=> o_pready ##1 !o_pready)
      else $error("apb answer not one cycle");
endmodule

/* tb/tb_llcev_counter.sv */
module tb_llcev_counter
   import llcev_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // stimulus and bookkeeping
   `define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
   localparam int LIMIT = 20000;
   localparam logic [7:0] A_SEL1 = ADDR_SEL0 + ADDR_STRIDE;
   localparam logic [7:0] A_CNT1 = ADDR_CNT0 + ADDR_STRIDE;
   typedef struct packed {
      logic [7:0] ev;
      logic [7:0] um;
      llcev_cache_t c;
      logic [11:0] t;
      logic [7:0] n;
   } llcev_row_t;
   logic i_clk = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
   logic i_bus_lock = 1'h0;
   logic i_ce = 1'h1;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, d, e;
   llcev_cache_t i_cache = '0;
   llcev_trk_t [NTRK-1:0] i_trk = '0;
   logic o_pready, o_pslverr, o_spec_fetch, o_fetch_cancel, er;
   logic [31:0] o_prdata;
   logic [NTRK-1:0] o_trk_full;
   int err_total = 0, checked = 0, cycles = 0;
   llcev_row_t rows [0:31] = '{
      '{8'h08, 8'h01, 18'h32000, 12'h000, 8'h01}, '{8'h08, 8'h02, 18'h32000, 12'h000, 8'h00},
      '{8'h08, 8'h02, 18'h2A000, 12'h000, 8'h01}, '{8'h08, 8'h03, 18'h2B000, 12'h000, 8'h00},
      '{8'h08, 8'h03, 18'h32000, 12'h000, 8'h01}, '{8'h08, 8'h04, 18'h27000, 12'h000, 8'h01},
      '{8'h08, 8'h01, 18'h30000, 12'h000, 8'h00}, '{8'h09, 8'h01, 18'h30000, 12'h000, 8'h01},
      '{8'h09, 8'h02, 18'h28000, 12'h000, 8'h01}, '{8'h09, 8'h03, 18'h31000, 12'h000, 8'h00},
      '{8'h09, 8'h03, 18'h28000, 12'h000, 8'h01}, '{8'h09, 8'h04, 18'h25000, 12'h000, 8'h01},
      '{8'h0A, 8'h01, 18'h00880, 12'h000, 8'h01}, '{8'h0A, 8'h02, 18'h00900, 12'h000, 8'h01},
      '{8'h0A, 8'h04, 18'h00A00, 12'h000, 8'h01}, '{8'h0A, 8'h08, 18'h00C00, 12'h000, 8'h01},
      '{8'h0A, 8'h0F, 18'h00900, 12'h000, 8'h01}, '{8'h0A, 8'h01, 18'h00900, 12'h000, 8'h00},
      '{8'h0B, 8'h01, 18'h00042, 12'h000, 8'h01}, '{8'h0B, 8'h02, 18'h00044, 12'h000, 8'h01},
      '{8'h0B, 8'h04, 18'h00048, 12'h000, 8'h01}, '{8'h0B, 8'h08, 18'h00050, 12'h000, 8'h01},
      '{8'h0B, 8'h10, 18'h00060, 12'h000, 8'h01}, '{8'h0B, 8'h1F, 18'h00060, 12'h000, 8'h01},
      '{8'h0B, 8'h02, 18'h00048, 12'h000, 8'h00}, '{8'h20, 8'h01, 18'h00000, 12'h008, 8'h01},
      '{8'h20, 8'h02, 18'h00000, 12'h00C, 8'h01}, '{8'h20, 8'h04, 18'h00000, 12'h080, 8'h01},
      '{8'h20, 8'h08, 18'h00000, 12'h0C0, 8'h01}, '{8'h20, 8'h10, 18'h00000, 12'h800, 8'h01},
      '{8'h20, 8'h20, 18'h00000, 12'hC00, 8'h01}, '{8'h20, 8'h3F, 18'h00000, 12'hC88, 8'h03}
   };

   llcev_counter u_llcev_counter (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_cache(i_cache),
      .i_trk(i_trk), .i_bus_lock(i_bus_lock), .o_spec_fetch(o_spec_fetch),
      .o_fetch_cancel(o_fetch_cancel), .o_trk_full(o_trk_full));

   always #25 i_clk = ~i_clk;

   // ==========================================
   // bus, event and closing tasks
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_total++;
         complete_run();
      end
   end

   // request held until pready is sampled high at a rising edge, then taken and released there
   // no local wait limit: only the bench timeout ends a hung transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_clk);
      i_psel <= 1'h1;
      i_penable <= 1'h0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'h1;
      do begin
         @(posedge i_clk);
      end while (o_pready !== 1'h1);
      d = o_prdata;
      er = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
   endtask

   task automatic pulse(input llcev_cache_t c, input logic [11:0] t);
      @(posedge i_clk);
      i_cache <= c;
      i_trk <= t;
      @(posedge i_clk);
      i_cache <= '0;
      i_trk <= '0;
   endtask

   // allocate a read entry in every tracker each cycle; refused ones must not count
   task automatic fill(input int k);
      for (int i = 0; i < k; i++) begin
         @(posedge i_clk);
         i_trk <= 12'h888;
      end
      @(posedge i_clk);
      i_trk <= '0;
      repeat (2) @(posedge i_clk);
   endtask

   task automatic do_reset();
      @(posedge i_clk);
      i_rst <= 1'h1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'h0;
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst <= 1'h0;
      foreach (rows[i]) begin
         apb(1'h1, ADDR_SEL0, {15'h0000, 1'h1, rows[i].um, rows[i].ev});
         apb(1'h1, ADDR_CNT0, 32'h0);
         pulse(rows[i].c, rows[i].t);
         apb(1'h0, ADDR_CNT0, 32'h0);
         `CHK("event row count", {24'h000000, rows[i].n}, d)
      end
      $display("test event table done");
      do_reset();
      apb(1'h0, ADDR_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h00000001, d)
      apb(1'h0, ADDR_SEL0, 32'h0);
      `CHK("sel reset", 32'h00000000, d)
      apb(1'h0, ADDR_CNT0, 32'h0);
      `CHK("cnt reset", 32'h00000000, d)
      apb(1'h1, ADDR_STAT, 32'hFFFFFFFF);
      apb(1'h0, ADDR_STAT, 32'h0);
      `CHK("stat read only", 32'h00000000, d)
      apb(1'h0, 8'h40, 32'h0);
      `CHK("unmapped error", 1'h1, er)
      `CHK("unmapped data", 32'h00000000, d)
      $display("test reset and map done");
      // dual depths: remote fills at 16, local and io hub at 24
      apb(1'h1, ADDR_SEL0, 32'h0001_0721);
      apb(1'h1, A_SEL1, 32'h0001_3F20);
      fill(15);
      `CHK("full after 15", 3'h0, o_trk_full)
      fill(1);
      `CHK("full after 16", 3'h2, o_trk_full)
      fill(8);
      `CHK("full after 24", 3'h7, o_trk_full)
      apb(1'h0, A_CNT1, 32'h0);
      `CHK("accepted requests", 32'd64, d)
      apb(1'h0, ADDR_CNT0, 32'h0);
      e = d;
      apb(1'h0, ADDR_CNT0, 32'h0);
      `CHK("full cycles", 32'd9, d - e)
      apb(1'h1, ADDR_SEL0, 32'h0001_0421);
      apb(1'h0, ADDR_CNT0, 32'h0);
      e = d;
      apb(1'h0, ADDR_CNT0, 32'h0);
      `CHK("local full cycles", 32'd3, d - e)
      // single socket: no remote tracker, the other two grow to 32
      apb(1'h1, ADDR_CTRL, 32'h0);
      repeat (2) @(posedge i_clk);
      `CHK("full single 24", 1'h0, o_trk_full[TRK_LOC])
      fill(8);
      `CHK("full single 32", 2'h3, {o_trk_full[TRK_LOC], o_trk_full[TRK_IO]})
      apb(1'h0, A_CNT1, 32'h0);
      `CHK("single requests", 32'd80, d)
      $display("test tracker depth done");
      // occupancy stays at zero until a bus lock arms it
      do_reset();
      apb(1'h1, ADDR_SEL0, 32'h0001_0423);
      apb(1'h1, A_SEL1, 32'h0001_0422);
      pulse('0, 12'h800);
      pulse('0, 12'h800);
      pulse('0, 12'hC00);
      apb(1'h0, ADDR_CNT0, 32'h0);
      `CHK("occupancy unarmed", 32'h00000000, d)
      pulse('0, 12'h000);
      i_bus_lock <= 1'h1;
      @(posedge i_clk);
      i_bus_lock <= 1'h0;
      apb(1'h0, ADDR_STAT, 32'h0);
      `CHK("armed flag", 1'h1, d[STAT_ARM_LSB])
      apb(1'h0, ADDR_CNT0, 32'h0);
      e = d;
      apb(1'h0, ADDR_CNT0, 32'h0);
      `CHK("read occupancy", 32'd6, d - e)
      apb(1'h0, A_CNT1, 32'h0);
      e = d;
      apb(1'h0, A_CNT1, 32'h0);
      `CHK("busy cycles", 32'd3, d - e)
      // clock enable low for five edges: occupancy must not move meanwhile
      apb(1'h0, ADDR_CNT0, 32'h0);
      e = d;
      i_ce <= 1'h0;
      repeat (5) @(posedge i_clk);
      i_ce <= 1'h1;
      apb(1'h0, ADDR_CNT0, 32'h0);
      `CHK("frozen occupancy", 32'd6, d - e)
      $display("test occupancy done");
      // link miss must not fetch; local miss fetches, hit-modified snoop cancels
      do_reset();
      pulse(18'h31000, 12'h000);
      @(negedge i_clk);
      `CHK("link miss fetch", 1'h0, o_spec_fetch)
      pulse(18'h30000, 12'h000);
      @(negedge i_clk);
      `CHK("spec fetch", 1'h1, o_spec_fetch)
      pulse(18'h00001, 12'h000);
      @(negedge i_clk);
      `CHK("fetch cancel", 1'h1, o_fetch_cancel)
      $display("test fetch done");
      complete_run();
   end
endmodule
